/* rtl/pss_pkg.sv */
// holds offsets, field positions, reset values and state codes of the
// power-save controller; assumes a 32-bit axi4-lite register bus.
package pss_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PSS_OFF_PCR = 8'h00;
  localparam logic [7:0] PSS_OFF_CFG = 8'h04;
  localparam logic [7:0] PSS_OFF_SSEL = 8'h08;
  localparam logic [7:0] PSS_OFF_STAT = 8'h0c;

  // ==========================================================
  // power_save_control_reg fields
  localparam int PSS_PCR_IDLE = 1;
  localparam int PSS_PCR_STOP = 2;

  // ==========================================================
  // configuration register fields
  localparam int PSS_CFG_SUB_PRESENT = 0;
  localparam int PSS_CFG_CPU_ON_SUB = 1;
  localparam int PSS_CFG_T16A_WTI = 2;
  localparam int PSS_CFG_WATCH_SUB = 3;
  localparam int PSS_CFG_T8C_SUB = 4;
  localparam int PSS_CFG_T8D_SUB = 5;
  localparam int PSS_CFG_CSI_EXT = 6;
  localparam int PSS_CFG_UART_EXT = 9;
  localparam int PSS_CFG_RTO_EN = 11;
  localparam int PSS_CFG_RTO_SEL_D = 12;
  localparam int PSS_CFG_W = 13;
  localparam logic [12:0] PSS_CFG_RST = 13'h0001;

  // ==========================================================
  // settle select, status and bus answers
  localparam int PSS_SSEL_W = 3;
  localparam logic [2:0] PSS_SSEL_RST = 3'h4;
  localparam logic [2:0] PSS_SSEL_MAX = 3'h4;
  localparam logic [1:0] PSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PSS_RUN = 2'b00,
    PSS_IDLE = 2'b01,
    PSS_STOP = 2'b10,
    PSS_SETTLE = 2'b11
  } pss_state_e;

endpackage

/* rtl/pss_power_save.sv */
// power-save controller: idle and software stop modes, clock gating,
// peripheral run enables and the stop-release settle counter.
// assumes wake_irq is already masked and limited to live sources.
`timescale 1ns/1ns
module pss_power_save
  import pss_pkg::*;
#(
  parameter int SETTLE_BASE_LOG2 = 13,
  parameter int ADDR_W = 32
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // wake and bus hold
  input wire logic nmi,
  input wire logic wake_irq,
  input wire logic bus_hold_request,
  output logic bus_hold_ack,
  // clock control
  output logic main_osc_en,
  output logic main_clk_en,
  output logic sub_clk_en,
  output logic cpu_run,
  // peripheral run enables
  output logic timer16_a_run,
  output logic watch_run,
  output logic timer8_c_run,
  output logic timer8_d_run,
  output logic [2:0] clocked_serial_ports_run,
  output logic [1:0] uart_tx_run,
  output logic [1:0] uart_rx_run,
  output logic rto_run,
  output logic periph_run
);

  localparam int CW = SETTLE_BASE_LOG2 + 5;

  // ==========================================================
  // parameter check at elaboration; out-of-range values would
  // overflow the settle counter or the offset decode
  if (SETTLE_BASE_LOG2 < 1 || SETTLE_BASE_LOG2 > 24) begin : g_chk_base
    $error("SETTLE_BASE_LOG2 out of range");
  end
  if (ADDR_W < 8) begin : g_chk_addr
    $error("ADDR_W must be at least 8");
  end

  // ==========================================================
  // all state of the block
  typedef struct packed {
    pss_state_e state;
    logic idle_req;
    logic stop_req;
    logic [PSS_CFG_W-1:0] cfg;
    logic [PSS_SSEL_W-1:0] ssel;
    logic [CW-1:0] cnt;
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic hold_ack;
    logic main_osc_en;
    logic main_clk_en;
    logic sub_clk_en;
    logic cpu_run;
    logic t16a;
    logic watch;
    logic t8c;
    logic t8d;
    logic [2:0] csi;
    logic [1:0] utx;
    logic [1:0] urx;
    logic rto;
    logic periph;
  } pss_state_s;

  pss_state_s s_q;
  pss_state_s s_d;

  // settle length as a one-hot count; selects above the top are clamped
  function automatic logic [CW-1:0] settle_len(input logic [2:0] sel);
    logic [2:0] k;
    k = (sel > PSS_SSEL_MAX) ? PSS_SSEL_MAX : sel;
    settle_len = CW'(1) << (SETTLE_BASE_LOG2 + int'(k));
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic do_wr;
    logic low_pwr;
    logic sub;
    logic [7:0] ra;
    do_wr = 1'b0;
    low_pwr = 1'b0;
    sub = 1'b0;
    ra = 8'h00;
    s_d = s_q;

    // write channel capture, either order
    if (awvalid && s_q.awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = awaddr[7:0];
    end
    if (wvalid && s_q.wready) begin
      s_d.w_v = 1'b1;
      s_d.w_d = wdata;
      s_d.w_s = wstrb;
    end
    if (bready && s_q.bvalid) begin
      s_d.bvalid = 1'b0;
    end
    do_wr = s_q.aw_v && s_q.w_v && !s_q.bvalid;

    // mode sequencing; wake is only looked at outside run
    unique case (s_q.state)
      PSS_RUN: begin
        s_d.cnt = '0;
      end
      PSS_IDLE: begin
        if (nmi || wake_irq) begin
          s_d.state = PSS_RUN; // no settle wait
          s_d.idle_req = 1'b0;
        end
      end
      PSS_STOP: begin
        if (nmi || wake_irq) begin
          s_d.state = PSS_SETTLE;
          s_d.cnt = settle_len(s_q.ssel);
        end
      end
      PSS_SETTLE: begin
        // settle counter counts down the oscillator settle time
        if (s_q.cnt <= CW'(1)) begin
          s_d.state = PSS_RUN;
          s_d.stop_req = 1'b0;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
    endcase

    // register write; mode entry only from run, so cpu is executing
    if (do_wr) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = PSS_RESP_OKAY;
      unique case (s_q.aw_a)
        PSS_OFF_PCR: begin
          if (s_q.w_s[0] && s_q.state == PSS_RUN) begin
            // stop wins when both are set; refused on subclock cpu
            if (s_q.w_d[PSS_PCR_STOP] && !s_q.cfg[PSS_CFG_CPU_ON_SUB]) begin
              s_d.state = PSS_STOP;
              s_d.stop_req = 1'b1;
            end else if (s_q.w_d[PSS_PCR_IDLE]) begin
              s_d.state = PSS_IDLE;
              s_d.idle_req = 1'b1;
            end
          end
        end
        PSS_OFF_CFG: begin
          if (s_q.w_s[0]) begin
            s_d.cfg[7:0] = s_q.w_d[7:0];
          end
          if (s_q.w_s[1]) begin
            s_d.cfg[PSS_CFG_W-1:8] = s_q.w_d[PSS_CFG_W-1:8];
          end
        end
        PSS_OFF_SSEL: begin
          if (s_q.w_s[0]) begin
            s_d.ssel = s_q.w_d[PSS_SSEL_W-1:0];
          end
        end
        PSS_OFF_STAT: begin
          s_d.bresp = PSS_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          s_d.bresp = PSS_RESP_SLVERR;
        end
      endcase
    end

    // read channel
    if (rready && s_q.rvalid) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      ra = araddr[7:0];
      s_d.rvalid = 1'b1;
      s_d.rresp = PSS_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      unique case (ra)
        PSS_OFF_PCR: begin
          s_d.rdata[PSS_PCR_IDLE] = s_q.idle_req;
          s_d.rdata[PSS_PCR_STOP] = s_q.stop_req;
        end
        PSS_OFF_CFG: begin
          s_d.rdata[PSS_CFG_W-1:0] = s_q.cfg;
        end
        PSS_OFF_SSEL: begin
          s_d.rdata[PSS_SSEL_W-1:0] = s_q.ssel;
        end
        PSS_OFF_STAT: begin
          s_d.rdata[1:0] = s_q.state;
          s_d.rdata[31:8] = 24'(s_q.cnt);
        end
        default: begin
          s_d.rresp = PSS_RESP_SLVERR;
        end
      endcase
    end

    // ready flags registered so the outputs come from flops
    s_d.awready = !s_d.aw_v && !s_d.bvalid;
    s_d.wready = !s_d.w_v && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;

    // clock and peripheral control follows the next mode, so the
    // gates change in the same edge as the state
    low_pwr = (s_d.state != PSS_RUN);
    sub = s_d.cfg[PSS_CFG_SUB_PRESENT];
    s_d.main_osc_en = !(s_d.state == PSS_STOP);
    s_d.main_clk_en = !low_pwr;
    s_d.sub_clk_en = sub;
    s_d.cpu_run = !low_pwr;
    s_d.hold_ack = !low_pwr && bus_hold_request;
    if (!low_pwr) begin
      s_d.periph = 1'b1;
      s_d.t16a = 1'b1;
      s_d.watch = 1'b1;
      s_d.t8c = 1'b1;
      s_d.t8d = 1'b1;
      s_d.csi = 3'h7;
      s_d.utx = 2'h3;
      s_d.urx = 2'h3;
      s_d.rto = 1'b1;
    end else begin
      s_d.periph = 1'b0;
      s_d.watch = sub && s_d.cfg[PSS_CFG_WATCH_SUB];
      s_d.t16a = s_d.watch && s_d.cfg[PSS_CFG_T16A_WTI];
      s_d.t8c = sub && s_d.cfg[PSS_CFG_T8C_SUB];
      s_d.t8d = sub && s_d.cfg[PSS_CFG_T8D_SUB];
      s_d.csi = s_d.cfg[PSS_CFG_CSI_EXT +: 3];
      s_d.utx = s_d.cfg[PSS_CFG_UART_EXT +: 2];
      s_d.urx = 2'h0; // receive has no clock here
      s_d.rto = s_d.cfg[PSS_CFG_RTO_EN] &&
        (s_d.cfg[PSS_CFG_RTO_SEL_D] ? s_d.t8d : s_d.t8c);
    end
  end

  // ==========================================================
  // state register; reset releases any mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.state <= PSS_RUN;
      s_q.cfg <= PSS_CFG_RST;
      s_q.ssel <= PSS_SSEL_RST;
      s_q.main_osc_en <= 1'b1;
      s_q.main_clk_en <= 1'b1;
      s_q.sub_clk_en <= 1'b1;
      s_q.cpu_run <= 1'b1;
      s_q.periph <= 1'b1;
      s_q.t16a <= 1'b1;
      s_q.watch <= 1'b1;
      s_q.t8c <= 1'b1;
      s_q.t8d <= 1'b1;
      s_q.csi <= 3'h7;
      s_q.utx <= 2'h3;
      s_q.urx <= 2'h3;
      s_q.rto <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign bus_hold_ack = s_q.hold_ack;
  assign main_osc_en = s_q.main_osc_en;
  assign main_clk_en = s_q.main_clk_en;
  assign sub_clk_en = s_q.sub_clk_en;
  assign cpu_run = s_q.cpu_run;
  assign timer16_a_run = s_q.t16a;
  assign watch_run = s_q.watch;
  assign timer8_c_run = s_q.t8c;
  assign timer8_d_run = s_q.t8d;
  assign clocked_serial_ports_run = s_q.csi;
  assign uart_tx_run = s_q.utx;
  assign uart_rx_run = s_q.urx;
  assign rto_run = s_q.rto;
  assign periph_run = s_q.periph;

endmodule

/* verification/pss_checker.sv */
// checker for the power-save controller: mode outputs and bus hold.
// assumes ce is held high, so every clock edge advances the block.
`timescale 1ns/1ns
module pss_checker #(
  parameter int SETTLE_BASE_LOG2 = 13
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // wake and bus hold
  input wire logic nmi,
  input wire logic wake_irq,
  input wire logic bus_hold_request,
  input wire logic bus_hold_ack,
  // clock control and run enables
  input wire logic main_osc_en,
  input wire logic main_clk_en,
  input wire logic sub_clk_en,
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic [1:0] uart_rx_run
);
  localparam int MINS = 1 << SETTLE_BASE_LOG2;
  localparam int MAXS = 1 << (SETTLE_BASE_LOG2 + 4);
  logic stop_q;
  logic [31:0] cnt_q;
  logic wake;
  assign wake = nmi || wake_irq;

  // ==========================================================
  // helper: stop seen since last run, cycles since oscillator restart
  // (idle also counts, but the settle check is gated by stop_q)
  always_ff @(posedge aclk) begin
    if (!aresetn || cpu_run) begin
      stop_q <= 1'b0;
    end else if (!main_osc_en) begin
      stop_q <= 1'b1;
    end
    if (!aresetn || !main_osc_en) begin
      cnt_q <= 32'h0;
    end else if (!cpu_run) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // mode assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_idle_gate: assert property (
    !cpu_run |-> !main_clk_en && !periph_run && $stable(sub_clk_en))
    else $error("clock or peripherals left on while asleep");
  a_stop_gate: assert property (
    !main_osc_en |-> !main_clk_en && !cpu_run && !periph_run
      && $stable(sub_clk_en))
    else $error("stop mode outputs wrong");
  a_run_clocks: assert property (
    cpu_run |-> main_clk_en && main_osc_en && periph_run)
    else $error("clocks off while running");
  a_idle_wake: assert property (
    !cpu_run && main_osc_en && !stop_q && wake |=> cpu_run)
    else $error("idle not left one edge after wake");
  a_stop_wake: assert property (
    !main_osc_en && wake |=> main_osc_en && !cpu_run)
    else $error("stop wake skipped settle");
  a_settle_len: assert property (
    $rose(cpu_run) && stop_q |-> cnt_q >= MINS - 1 && cnt_q <= MAXS + 1)
    else $error("settle interval out of range");
  a_hold_refused: assert property (
    !cpu_run && !$past(cpu_run) |-> !bus_hold_ack)
    else $error("bus hold granted while asleep");
  a_hold_grant: assert property (
    cpu_run && $past(cpu_run) && $past(cpu_run, 2) && $past(aresetn)
      && $past(aresetn, 2) |-> bus_hold_ack == $past(bus_hold_request))
    else $error("bus hold ack does not follow request in run");
  a_uart_rx: assert property (
    !cpu_run |-> uart_rx_run == 2'b00)
    else $error("uart receive left on while asleep");
endmodule

bind pss_power_save pss_checker #(.SETTLE_BASE_LOG2(SETTLE_BASE_LOG2)) u_chk (
  .aclk, .aresetn, .nmi, .wake_irq, .bus_hold_request, .bus_hold_ack,
  .main_osc_en, .main_clk_en, .sub_clk_en, .cpu_run, .periph_run,
  .uart_rx_run);

/* verification/pss_wake_model.sv */
// wake-source model: non-maskable and live peripheral interrupt lines.
// assumes the bench pulses a request only while the block is asleep.
`timescale 1ns/1ns
module pss_wake_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bench commands and cpu status
  input wire logic want_nmi,
  input wire logic want_irq,
  input wire logic cpu_run,
  // wake lines
  output logic nmi,
  output logic wake_irq
);
  // ==========================================================
  // a request is a level held until the cpu runs and services it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      nmi <= want_nmi || (nmi && !cpu_run);
      wake_irq <= want_irq || (wake_irq && !cpu_run);
    end
  end
endmodule

/* verification/pss_power_save_tb.sv */
// testbench for the power-save controller over axi4-lite.
// assumes the settle base is shortened to 2 so stop wakes stay short.
`timescale 1ns/1ns
module pss_power_save_tb
  import pss_pkg::*;
;
  // ==========================================================
  // signals; ce, prot and strobes are tied
  logic aclk = 0, aresetn = 0, ce = 1, hold_req = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, bus_hold_ack;
  logic [31:0] awaddr = 0, araddr = 0, wdata = 0, rdata;
  logic [1:0] bresp, rresp, utx, urx;
  logic nmi, wake_irq, want_nmi = 0, want_irq = 0;
  logic main_osc_en, main_clk_en, sub_clk_en, cpu_run;
  logic t16a, watch, t8c, t8d, rto, periph;
  logic [2:0] csp;
  logic [17:0] outs;
  int err_total = 0, n_tests = 0, n, n0, ni;
  assign outs = {bus_hold_ack, t16a, watch, t8c, t8d, csp, utx, urx, rto,
    periph, cpu_run, main_clk_en, main_osc_en, sub_clk_en};

  // clock, 100 ns period
  initial begin
    forever #50 aclk = ~aclk;
  end

  // ==========================================================
  // design and wake sources
  pss_power_save #(.SETTLE_BASE_LOG2(2)) uut (
    .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
    .rresp, .nmi, .wake_irq, .bus_hold_request(hold_req), .bus_hold_ack,
    .main_osc_en, .main_clk_en, .sub_clk_en, .cpu_run,
    .timer16_a_run(t16a), .watch_run(watch), .timer8_c_run(t8c),
    .timer8_d_run(t8d), .clocked_serial_ports_run(csp), .uart_tx_run(utx),
    .uart_rx_run(urx), .rto_run(rto), .periph_run(periph));
  pss_wake_model u_wake (.aclk, .aresetn, .want_nmi, .want_irq, .cpu_run,
    .nmi, .wake_irq);

  // ==========================================================
  // verdict, compare and bounded edge wait
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic step(inout int c);
    @(posedge aclk);
    c++;
    if (c > 400) begin
      err_total++;
      $display("wrong value at %0t: wait ran out", $time);
      final_report();
    end
  endtask

  // ==========================================================
  // bus tasks: hold each channel until its own ready is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int c;
    logic ad;
    logic wd;
    c = 0;
    ad = 0;
    wd = 0;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      step(c);
      if (awready === 1'b1 && !ad) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do step(c); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] e);
    int c;
    c = 0;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do step(c); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do step(c); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, e});
  endtask

  // one-cycle wake command, then edges until the cpu runs again
  task automatic wake(input logic use_nmi, output int c);
    c = 0;
    want_nmi <= use_nmi;
    want_irq <= !use_nmi;
    @(posedge aclk);
    want_nmi <= 1'b0;
    want_irq <= 1'b0;
    do step(c); while (cpu_run !== 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PSS_OFF_PCR, 32'h0, PSS_RESP_OKAY);
    rd(PSS_OFF_CFG, 32'(PSS_CFG_RST), PSS_RESP_OKAY);
    rd(PSS_OFF_SSEL, 32'(PSS_SSEL_RST), PSS_RESP_OKAY);
    rd(8'h10, 32'h0, PSS_RESP_SLVERR);
    wr(8'h14, 32'h1, PSS_RESP_SLVERR);
    chk(32'(outs), 32'h3ffff);
    // hold request dropped in run: the grant follows one edge later
    hold_req <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(bus_hold_ack), 32'h0);
    hold_req <= 1'b1;
    $display("test reset done");
    // idle with subclock-clocked timers, live irq wakes at once
    wr(PSS_OFF_CFG, 32'hb5d, PSS_RESP_OKAY);
    wr(PSS_OFF_PCR, 32'h2, PSS_RESP_OKAY);
    chk(32'(outs), 32'h1d523);
    rd(PSS_OFF_PCR, 32'h2, PSS_RESP_OKAY);
    rd(PSS_OFF_STAT, 32'h1, PSS_RESP_OKAY);
    wake(1'b0, ni);
    chk(32'(ni), 32'd2);
    rd(PSS_OFF_PCR, 32'h0, PSS_RESP_OKAY);
    // idle without subclock: its enable, timers and trigger stay off
    wr(PSS_OFF_CFG, 32'hb5c, PSS_RESP_OKAY);
    wr(PSS_OFF_PCR, 32'h2, PSS_RESP_OKAY);
    chk(32'(outs), 32'h01502);
    wake(1'b1, n);
    chk(32'(n), 32'd2);
    $display("test idle done");
    // stop refused while the cpu runs on the subclock
    wr(PSS_OFF_CFG, 32'hb5f, PSS_RESP_OKAY);
    wr(PSS_OFF_PCR, 32'h4, PSS_RESP_OKAY);
    chk(32'(outs), 32'h3ffff);
    rd(PSS_OFF_PCR, 32'h0, PSS_RESP_OKAY);
    // stop with two settle selects; one step doubles the settle;
    // trigger on timer8_d, which is not on the subclock, so rto stops
    wr(PSS_OFF_CFG, 32'h1b5d, PSS_RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(PSS_OFF_SSEL, 32'(i), PSS_RESP_OKAY);
      wr(PSS_OFF_PCR, 32'h4, PSS_RESP_OKAY);
      chk(32'(outs), 32'h1d501);
      wake(1'b1, n);
      if (i == 0) n0 = n;
    end
    chk(32'(n0 - ni), 32'd4);
    chk(32'(n - n0), 32'd4);
    rd(PSS_OFF_PCR, 32'h0, PSS_RESP_OKAY);
    $display("test stop done");
    // reset pin ends idle
    wr(PSS_OFF_PCR, 32'h2, PSS_RESP_OKAY);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(PSS_OFF_PCR, 32'h0, PSS_RESP_OKAY);
    chk(32'(outs), 32'h3ffff);
    $display("test reset wake done");
    final_report();
  end
endmodule
